/* File: hw/tifd_pkg.sv */
// Constants, register map and enumerations for the terminal decoder.
// Assumes a 125 MHz APB clock; offsets are byte addresses.
package tifd_pkg;
  // Clock and filter timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILT_UNIT_NS = 1000;
  localparam int FILT_TICK_CYC = FILT_UNIT_NS / CLK_PERIOD_NS;
  localparam int NUM_TERM = 16;
  localparam int FN_W = 6;
  localparam int FILT_W = 16;
  // Register offsets
  localparam logic [11:0] OFF_POL = 12'h000;
  localparam logic [11:0] OFF_FILT = 12'h004;
  localparam logic [11:0] OFF_SCHEME = 12'h008;
  localparam logic [11:0] OFF_CTRL = 12'h00C;
  localparam logic [11:0] OFF_STAT = 12'h010;
  localparam logic [11:0] OFF_BRK = 12'h014;
  localparam logic [11:0] OFF_FN_BASE = 12'h040;
  // Reset values
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] FILT_RST = 16'h0014;
  localparam logic [5:0] FN_RST = 6'h00;
  // Control and status field positions
  localparam int CTRL_ISO_BIT = 0;
  localparam int CTRL_SHARE_BIT = 1;
  localparam int CTRL_REMOTE_BIT = 2;
  localparam int CTRL_COMM_LSB = 4;
  localparam int CTRL_TRIPCLR_BIT = 8;
  localparam int STAT_TRIP_BIT = 4;
  localparam int STAT_ADDR_LSB = 5;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_REV_BIT = 9;
  localparam int STAT_IN_LSB = 16;
  // Terminal function codes
  localparam logic [5:0] FN_FWD = 6'h01;
  localparam logic [5:0] FN_REV = 6'h02;
  localparam logic [5:0] FN_3WIRE = 6'h03;
  localparam logic [5:0] FN_VF_RUN = 6'h18;
  localparam logic [5:0] FN_LINE_RUN = 6'h19;
  localparam logic [5:0] FN_VF2LINE = 6'h1A;
  localparam logic [5:0] FN_LINE2VF = 6'h1B;
  localparam logic [5:0] FN_HV_BREAK = 6'h1C;
  localparam logic [5:0] FN_PID_PAUSE = 6'h1D;
  localparam logic [5:0] FN_CAB_ADDR0 = 6'h20;
  localparam logic [5:0] FN_CAB_ADDR1 = 6'h21;
  localparam logic [5:0] FN_CAB_ADDR2 = 6'h22;
  localparam logic [5:0] FN_TO_LOCAL = 6'h23;
  localparam logic [5:0] FN_TO_TERM = 6'h24;
  localparam logic [5:0] FN_TO_COMM = 6'h25;
  localparam logic [5:0] FN_SPEED = 6'h28;
  localparam logic [5:0] FN_FREF_HOLD = 6'h2B;
  localparam logic [5:0] FN_BUF_FB = 6'h2C;
  localparam logic [5:0] FN_VF_BRK0 = 6'h30;
  localparam logic [5:0] FN_LINE_BRK0 = 6'h38;
  // Enumerations
  typedef enum logic [1:0] {SCH_2W1, SCH_2W2, SCH_3W1, SCH_3W2} scheme_e;
  typedef enum logic [1:0] {SRC_PANEL, SRC_TERM, SRC_COMM} cmd_src_e;
  typedef enum logic [1:0] {CAB_OFF, CAB_VF, CAB_LINE} cab_e;
endpackage

/* File: hw/filter_if.sv */
// Bundle between the decoder and its input filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface filter_if #(parameter int N = 16, parameter int TW = 16);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  logic [TW-1:0] ftime;
  modport src (output raw, output ftime, input clean);
  modport flt (input raw, input ftime, output clean);
endinterface

/* File: hw/input_filter.sv */
// Per-terminal stability filter with a shared time-base prescaler.
// Assumes raw inputs already polarity-corrected and synchronous.
`timescale 1ns/1ns
module input_filter #(
  parameter int N = 16,
  parameter int TW = 16,
  parameter int TICK_CYC = tifd_pkg::FILT_TICK_CYC
) (
  input logic pclk, // Bus clock
  input logic presetn, // Async reset, active low
  filter_if.flt f // Raw in, clean out
);
  localparam int PW = $clog2(TICK_CYC + 1);
  logic [PW-1:0] pre_r;
  logic tick;

  // One tick per filter time unit
  assign tick = (pre_r == PW'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Output follows input only after it held steady for ftime ticks
  for (genvar i = 0; i < N; i++) begin : g_bit
    logic [TW-1:0] cnt_r;
    logic q_r;
    assign f.clean[i] = q_r;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= '0;
        q_r <= 1'b0;
      end else if (f.raw[i] == q_r) begin
        cnt_r <= '0; // Any bounce back restarts the wait
      end else if (tick) begin
        if (({1'b0, cnt_r} + 1'b1) >= {1'b0, f.ftime}) begin
          q_r <= f.raw[i];
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule // input_filter

/* File: hw/terminal_input_function_decoder.sv */
// Sixteen multifunction on/off input terminals: filter, polarity and
// function decode, switch cabinet sequencing and run-command decode.
// Assumes an APB master on pclk and inputs synchronous to pclk.
// Contract
// - Line pulse from all open closes line
// - VF-to-line pulse swaps to line contactor
// - Line-to-VF pulse swaps to VF contactors
// - Sequencing only with isolated switch cabinet
// - Breaking pulse cuts supply power
// - PID pause holds output frequency
// - Three address bits select cabinet 1-8
// - Force command source to local panel
// - Force command source to terminals
// - Force command source to chosen channel
// - Forcing only while selector is remote
// - Force speed control over torque control
// - Freeze reference against external source
// - Function 44 means buffer cabinet feedback
// - Shared power: common breaker from both
// - Unshared: each feedback high means closed
// - Cabinet one breaker feedback codes 48/56
// - Cabinets 2-8 feedback codes 49-55/57-63
// - Polarity word, one bit per terminal
// - Programmable sampling filter, default 20
// - Run scheme select, codes 0 to 3
// - Two-wire mode 1 run decode
// - Two-wire mode 2 enable and direction
// - Three-wire mode 1 edge start
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
module terminal_input_function_decoder #(
  parameter int TICK_CYC = tifd_pkg::FILT_TICK_CYC
) (
  input logic pclk, // Bus and logic clock
  input logic presetn, // Async reset, active low
  input logic [11:0] paddr, // APB byte address
  input logic psel, // APB select
  input logic penable, // APB access phase
  input logic pwrite, // APB write
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input logic [15:0] multifunction_inputs, // Raw terminals
  output logic vf_contactor_a, // VF contactor a close
  output logic vf_contactor_b, // VF contactor b close
  output logic vf_contactor_c, // VF contactor c close
  output logic line_freq_contactor, // Line contactor close
  output logic supply_cut, // Supply cut request
  output logic pid_hold, // Suspend PID regulation
  output logic [3:0] cabinet_number, // Selected cabinet 1-8
  output logic force_src_valid, // Command source forced
  output logic [1:0] force_src, // Forced command source
  output logic [1:0] comm_channel, // Channel for comm source
  output logic speed_mode_force, // Speed instead of torque
  output logic freq_ref_freeze, // Ignore external ref
  output logic buffer_cab_installed, // Buffer cabinet fitted
  output logic buffer_contactor_fb, // Buffer contactor fb
  output logic common_breaker_closed, // Shared breaker state
  output logic [7:0] vf_breaker_fb, // VF breakers 1-8
  output logic [7:0] line_breaker_fb, // Line breakers 1-8
  output logic run_cmd, // Terminal run command
  output logic run_reverse // Run direction reverse
);
  logic [15:0] pol_r;
  logic [15:0] ftime_r;
  tifd_pkg::scheme_e scheme_r;
  logic iso_r;
  logic share_r;
  logic remote_r;
  logic [1:0] comm_r;
  logic [5:0] fn_r [16];
  logic wr;
  logic trip_clr;
  logic [31:0] rd_val;
  logic rd_err;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [63:0] act;
  logic [63:0] act_q;
  logic [63:0] rise;
  tifd_pkg::cab_e cab_r;
  logic supply_cut_r;
  logic run_r;
  logic rev_r;
  logic [2:0] cab_addr;
  logic buf_any;
  logic pid_hold_r;
  logic [3:0] cab_num_r;
  logic force_v_r;
  logic [1:0] force_src_r;
  logic speed_r;
  logic freeze_r;
  logic buf_inst_r;
  logic buf_fb_r;
  logic common_r;
  logic [7:0] vf_brk_r;
  logic [7:0] line_brk_r;

  filter_if #(.N(16), .TW(16)) fif ();

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    return a == off;
  endfunction

  // Function code table sits in one aligned block of sixteen words
  function automatic logic in_fn(input logic [11:0] a);
    return (a[11:6] == tifd_pkg::OFF_FN_BASE[11:6]) && (a[1:0] == 2'h0);
  endfunction

  assign wr = psel && penable && pwrite;
  assign trip_clr = wr && hit(paddr, tifd_pkg::OFF_CTRL) &&
                    pwdata[tifd_pkg::CTRL_TRIPCLR_BIT];
  // Zero wait states; data was captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= tifd_pkg::POL_RST;
      ftime_r <= tifd_pkg::FILT_RST;
      scheme_r <= tifd_pkg::SCH_2W1;
      iso_r <= 1'b0;
      share_r <= 1'b0;
      remote_r <= 1'b0;
      comm_r <= 2'h0;
    end else if (wr) begin
      if (hit(paddr, tifd_pkg::OFF_POL)) begin
        pol_r <= pwdata[15:0];
      end
      if (hit(paddr, tifd_pkg::OFF_FILT)) begin
        ftime_r <= pwdata[15:0];
      end
      if (hit(paddr, tifd_pkg::OFF_SCHEME)) begin
        scheme_r <= tifd_pkg::scheme_e'(pwdata[1:0]);
      end
      if (hit(paddr, tifd_pkg::OFF_CTRL)) begin
        iso_r <= pwdata[tifd_pkg::CTRL_ISO_BIT];
        share_r <= pwdata[tifd_pkg::CTRL_SHARE_BIT];
        remote_r <= pwdata[tifd_pkg::CTRL_REMOTE_BIT];
        comm_r <= pwdata[tifd_pkg::CTRL_COMM_LSB +: 2];
      end
    end
  end

  // Function code per terminal
  for (genvar i = 0; i < 16; i++) begin : g_fn
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fn_r[i] <= tifd_pkg::FN_RST;
      end else if (wr && in_fn(paddr) && (paddr[5:2] == 4'(i))) begin
        fn_r[i] <= pwdata[5:0];
      end
    end
  end

  // Read mux; writes to status words are silently dropped
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (in_fn(paddr)) begin
      rd_val[5:0] = fn_r[paddr[5:2]];
    end else if (hit(paddr, tifd_pkg::OFF_POL)) begin
      rd_val[15:0] = pol_r;
    end else if (hit(paddr, tifd_pkg::OFF_FILT)) begin
      rd_val[15:0] = ftime_r;
    end else if (hit(paddr, tifd_pkg::OFF_SCHEME)) begin
      rd_val[1:0] = scheme_r;
    end else if (hit(paddr, tifd_pkg::OFF_CTRL)) begin
      rd_val[tifd_pkg::CTRL_ISO_BIT] = iso_r;
      rd_val[tifd_pkg::CTRL_SHARE_BIT] = share_r;
      rd_val[tifd_pkg::CTRL_REMOTE_BIT] = remote_r;
      rd_val[tifd_pkg::CTRL_COMM_LSB +: 2] = comm_r;
    end else if (hit(paddr, tifd_pkg::OFF_STAT)) begin
      rd_val[3:0] = {line_freq_contactor, vf_contactor_c,
                     vf_contactor_b, vf_contactor_a};
      rd_val[tifd_pkg::STAT_TRIP_BIT] = supply_cut_r;
      rd_val[tifd_pkg::STAT_ADDR_LSB +: 3] = cab_addr;
      rd_val[tifd_pkg::STAT_RUN_BIT] = run_r;
      rd_val[tifd_pkg::STAT_REV_BIT] = rev_r;
      rd_val[tifd_pkg::STAT_IN_LSB +: 16] = fif.clean;
    end else if (hit(paddr, tifd_pkg::OFF_BRK)) begin
      rd_val[15:0] = {line_brk_r, vf_brk_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Capture answer in the setup cycle so data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= rd_err;
    end
  end

  // Polarity before filtering, so contacts of either kind filter alike
  assign fif.raw = multifunction_inputs ^ pol_r;
  assign fif.ftime = ftime_r;

  input_filter #(.N(16), .TW(16), .TICK_CYC(TICK_CYC)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif)
  );

  // Map terminals to functions; unused and reserved codes drive
  // entries that no logic below reads
  always_comb begin
    act = 64'h0;
    for (int i = 0; i < 16; i++) begin
      act[fn_r[i]] = act[fn_r[i]] | fif.clean[i];
    end
  end

  // Function 44 on any terminal marks the buffer cabinet present
  always_comb begin
    buf_any = 1'b0;
    for (int i = 0; i < 16; i++) begin
      buf_any = buf_any | (fn_r[i] == tifd_pkg::FN_BUF_FB);
    end
  end

  // Pulse functions act on the rising edge of the clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 64'h0;
    end else begin
      act_q <= act;
    end
  end
  assign rise = act & ~act_q;

  // Cabinet sequencing; pulses that do not fit the state are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cab_r <= tifd_pkg::CAB_OFF;
    end else if (iso_r) begin
      case (cab_r)
        tifd_pkg::CAB_OFF: begin
          if (rise[tifd_pkg::FN_VF_RUN]) begin
            cab_r <= tifd_pkg::CAB_VF; // VF run wins a tie
          end else if (rise[tifd_pkg::FN_LINE_RUN]) begin
            cab_r <= tifd_pkg::CAB_LINE;
          end
        end
        tifd_pkg::CAB_VF: begin
          if (rise[tifd_pkg::FN_VF2LINE]) begin
            cab_r <= tifd_pkg::CAB_LINE;
          end
        end
        tifd_pkg::CAB_LINE: begin
          if (rise[tifd_pkg::FN_LINE2VF]) begin
            cab_r <= tifd_pkg::CAB_VF;
          end
        end
        default: cab_r <= tifd_pkg::CAB_OFF;
      endcase
    end
  end
  assign vf_contactor_a = (cab_r == tifd_pkg::CAB_VF);
  assign vf_contactor_b = (cab_r == tifd_pkg::CAB_VF);
  assign vf_contactor_c = (cab_r == tifd_pkg::CAB_VF);
  assign line_freq_contactor = (cab_r == tifd_pkg::CAB_LINE);

  // Sticky supply cut; a new pulse beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_cut_r <= 1'b0;
    end else if (rise[tifd_pkg::FN_HV_BREAK]) begin
      supply_cut_r <= 1'b1;
    end else if (trip_clr) begin
      supply_cut_r <= 1'b0;
    end
  end
  assign supply_cut = supply_cut_r;

  assign cab_addr = {act[tifd_pkg::FN_CAB_ADDR2],
                     act[tifd_pkg::FN_CAB_ADDR1],
                     act[tifd_pkg::FN_CAB_ADDR0]};

  // Level functions, registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pid_hold_r <= 1'b0;
      cab_num_r <= 4'h1;
      force_v_r <= 1'b0;
      force_src_r <= tifd_pkg::SRC_PANEL;
      speed_r <= 1'b0;
      freeze_r <= 1'b0;
      buf_inst_r <= 1'b0;
      buf_fb_r <= 1'b0;
      common_r <= 1'b0;
      vf_brk_r <= 8'h00;
      line_brk_r <= 8'h00;
    end else begin
      pid_hold_r <= act[tifd_pkg::FN_PID_PAUSE];
      cab_num_r <= {1'b0, cab_addr} + 4'h1;
      force_v_r <= remote_r && (act[tifd_pkg::FN_TO_LOCAL] ||
                   act[tifd_pkg::FN_TO_TERM] ||
                   act[tifd_pkg::FN_TO_COMM]);
      // Local panel outranks terminals, which outrank comms
      if (act[tifd_pkg::FN_TO_LOCAL]) begin
        force_src_r <= tifd_pkg::SRC_PANEL;
      end else if (act[tifd_pkg::FN_TO_TERM]) begin
        force_src_r <= tifd_pkg::SRC_TERM;
      end else if (act[tifd_pkg::FN_TO_COMM]) begin
        force_src_r <= tifd_pkg::SRC_COMM;
      end
      speed_r <= act[tifd_pkg::FN_SPEED];
      freeze_r <= act[tifd_pkg::FN_FREF_HOLD];
      buf_inst_r <= buf_any;
      buf_fb_r <= act[tifd_pkg::FN_BUF_FB];
      // Either main feedback on closes the shared breaker
      common_r <= share_r && (act[tifd_pkg::FN_VF_BRK0] ||
                  act[tifd_pkg::FN_LINE_BRK0]);
      vf_brk_r <= act[tifd_pkg::FN_VF_BRK0 +: 8];
      line_brk_r <= act[tifd_pkg::FN_LINE_BRK0 +: 8];
    end
  end
  assign pid_hold = pid_hold_r;
  assign cabinet_number = cab_num_r;
  assign force_src_valid = force_v_r;
  assign force_src = force_src_r;
  assign comm_channel = comm_r;
  assign speed_mode_force = speed_r;
  assign freq_ref_freeze = freeze_r;
  assign buffer_cab_installed = buf_inst_r;
  assign buffer_contactor_fb = buf_fb_r;
  assign common_breaker_closed = common_r;
  assign vf_breaker_fb = vf_brk_r;
  assign line_breaker_fb = line_brk_r;

  // Run command decode per terminal scheme
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      case (scheme_r)
        tifd_pkg::SCH_2W1: begin
          run_r <= act[tifd_pkg::FN_FWD] ^ act[tifd_pkg::FN_REV];
          rev_r <= act[tifd_pkg::FN_REV] & ~act[tifd_pkg::FN_FWD];
        end
        tifd_pkg::SCH_2W2: begin
          run_r <= act[tifd_pkg::FN_FWD];
          rev_r <= act[tifd_pkg::FN_REV];
        end
        tifd_pkg::SCH_3W1: begin
          if (!act[tifd_pkg::FN_3WIRE]) begin
            run_r <= 1'b0;
          end else if (rise[tifd_pkg::FN_FWD]) begin
            run_r <= 1'b1;
          end
          rev_r <= act[tifd_pkg::FN_REV];
        end
        tifd_pkg::SCH_3W2: begin
          // Each button latches its own direction
          if (!act[tifd_pkg::FN_3WIRE]) begin
            run_r <= 1'b0;
          end else if (rise[tifd_pkg::FN_FWD]) begin
            run_r <= 1'b1;
            rev_r <= 1'b0;
          end else if (rise[tifd_pkg::FN_REV]) begin
            run_r <= 1'b1;
            rev_r <= 1'b1;
          end
        end
        default: run_r <= 1'b0;
      endcase
    end
  end
  assign run_cmd = run_r;
  assign run_reverse = rev_r;

  // Checks on sequencing, latching and decode
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  line_close_a: assert property (iso_r && cab_r == tifd_pkg::CAB_OFF &&
    rise[tifd_pkg::FN_LINE_RUN] && !rise[tifd_pkg::FN_VF_RUN]
    |=> line_freq_contactor && !vf_contactor_a)
    else $error("line run pulse did not close line contactor");
  vf_to_line_a: assert property (iso_r && cab_r == tifd_pkg::CAB_VF &&
    rise[tifd_pkg::FN_VF2LINE] |=> line_freq_contactor && !vf_contactor_b)
    else $error("vf to line swap missing");
  line_to_vf_a: assert property (iso_r && cab_r == tifd_pkg::CAB_LINE &&
    rise[tifd_pkg::FN_LINE2VF] |=> vf_contactor_c && !line_freq_contactor)
    else $error("line to vf swap missing");
  no_cabinet_a: assert property (!iso_r |=> $stable(cab_r))
    else $error("contactors moved without isolated cabinet");
  trip_set_a: assert property (rise[tifd_pkg::FN_HV_BREAK]
    |=> supply_cut [*2])
    else $error("supply cut not held after break pulse");
  pid_hold_a: assert property (act[tifd_pkg::FN_PID_PAUSE] |=> pid_hold)
    else $error("pid hold not asserted");
  cab_addr_a: assert property (##1 cabinet_number ==
    {1'b0, $past(cab_addr)} + 4'h1)
    else $error("cabinet number wrong");
  force_local_a: assert property (!remote_r |=> !force_src_valid)
    else $error("forced source while local");
  two_wire_a: assert property (scheme_r == tifd_pkg::SCH_2W1 &&
    act[tifd_pkg::FN_FWD] && act[tifd_pkg::FN_REV] |=> !run_cmd)
    else $error("both run inputs must stop");
  three_wire_a: assert property (scheme_r == tifd_pkg::SCH_3W1 &&
    !act[tifd_pkg::FN_3WIRE] |=> !run_cmd)
    else $error("three wire run without enable");

  vf_reach_c: cover property (cab_r == tifd_pkg::CAB_VF);
  swap_c: cover property (cab_r == tifd_pkg::CAB_VF
    ##[1:1000] cab_r == tifd_pkg::CAB_LINE);
  trip_c: cover property ($rose(supply_cut));
  run_c: cover property (scheme_r == tifd_pkg::SCH_3W1 && $rose(run_cmd));
endmodule // terminal_input_function_decoder

/* File: testbench/field_model.sv */
// Field contacts, pushbuttons and cabinet feedback seen by the decoder.
// Assumes the bench calls set() and that pclk is the design clock.
`timescale 1ns/1ns
module field_model (
  input wire logic pclk, // Design clock
  output logic [15:0] multifunction_inputs // Contact levels
);
  // A contact moves only just after a rising edge, never mid-cycle
  task automatic set(input int t, input logic v);
    @(posedge pclk);
    multifunction_inputs[t] <= v;
  endtask
  // All contacts open at time zero
  initial multifunction_inputs = 16'h0000;
endmodule // field_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the terminal input function decoder.
// Assumes the APB slave answers on its own pready; filter tick is 1 cycle.
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] multifunction_inputs;
  logic vf_contactor_a, vf_contactor_b, vf_contactor_c, line_freq_contactor;
  logic supply_cut, pid_hold, force_src_valid, speed_mode_force;
  logic freq_ref_freeze, buffer_cab_installed, buffer_contactor_fb;
  logic common_breaker_closed, run_cmd, run_reverse;
  logic [3:0] cabinet_number;
  logic [1:0] force_src, comm_channel;
  logic [7:0] vf_breaker_fb, line_breaker_fb;
  int fails, comparisons;
  note_s q[$];
  localparam logic [23:0] LV_FN = {6'h2C, 6'h2B, 6'h28, 6'h1D};
  terminal_input_function_decoder #(.TICK_CYC(1)) dut (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .multifunction_inputs, .vf_contactor_a, .vf_contactor_b,
    .vf_contactor_c, .line_freq_contactor, .supply_cut, .pid_hold,
    .cabinet_number, .force_src_valid, .force_src, .comm_channel,
    .speed_mode_force, .freq_ref_freeze, .buffer_cab_installed,
    .buffer_contactor_fb, .common_breaker_closed, .vf_breaker_fb,
    .line_breaker_fb, .run_cmd, .run_reverse);
  field_model fm (.pclk, .multifunction_inputs);
  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // The expectation is noted before the read is issued
  task automatic rd(input logic [11:0] a, input logic [31:0] v, m,
                    input logic e);
    q.push_back('{v, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic fn(input int t, input logic [5:0] c);
    wr(tifd_pkg::OFF_FN_BASE + 12'(4 * t), {26'h0, c});
  endtask
  // Filter plus output register delay, with margin
  task automatic settle;
    repeat (10) @(posedge pclk);
  endtask
  task automatic rs(input logic [31:0] v, m);
    settle();
    rd(tifd_pkg::OFF_STAT, v, m, 1'b0);
  endtask
  task automatic pulse(input int t);
    fm.set(t, 1'b1);
    settle();
    fm.set(t, 1'b0);
  endtask
  // Read monitor: takes the oldest note when an access completes
  always @(posedge pclk) begin
    note_s n;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = q.pop_front();
      chk("prdata", prdata & n.m, n.v);
      chk("pslverr", {31'h0, pslverr}, {31'h0, n.e});
    end
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    end_of_test();
  end
  initial begin
    logic [2:0] c;
    logic [1:0] ch;
    int k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    comparisons = 0;
    void'($urandom(83931));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(tifd_pkg::OFF_POL, 32'h0, 32'hFFFF, 1'b0);
    rd(tifd_pkg::OFF_FILT, 32'h14, 32'hFFFF, 1'b0);
    rd(tifd_pkg::OFF_SCHEME, 32'h0, 32'h3, 1'b0);
    rd(12'h030, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(tifd_pkg::OFF_FILT, 32'h1);
    wr(tifd_pkg::OFF_CTRL, 32'h5);
    // Contactor sequencing, illegal pulses first
    fn(0, 6'h19);
    fn(1, 6'h1B);
    fn(2, 6'h1A);
    fn(13, 6'h1E);
    pulse(13);
    rs(32'h0, 32'hF);
    pulse(1);
    rs(32'h0, 32'hF);
    pulse(0);
    rs(32'h8, 32'hF);
    pulse(0);
    rs(32'h8, 32'hF);
    pulse(1);
    rs(32'h7, 32'hF);
    pulse(2);
    rs(32'h8, 32'hF);
    wr(tifd_pkg::OFF_CTRL, 32'h4);
    pulse(1);
    rs(32'h8, 32'hF);
    // Supply cut sticks until cleared
    fn(3, 6'h1C);
    pulse(3);
    rs(32'h10, 32'h10);
    wr(tifd_pkg::OFF_CTRL, 32'h104);
    rs(32'h0, 32'h10);
    // Random cabinet address
    for (int i = 0; i < 3; i++) fn(4 + i, 6'h20 + 6'(i));
    c = 3'($urandom_range(7, 0));
    for (int i = 0; i < 3; i++) fm.set(4 + i, c[i]);
    rs({24'h0, c, 5'h0}, 32'hE0);
    chk("cabinet_number", cabinet_number, c + 4'h1);
    // Forced command source, on remote then on local
    ch = 2'($urandom_range(3, 0));
    wr(tifd_pkg::OFF_CTRL, {26'h0, ch, 4'h4});
    for (int i = 0; i < 3; i++) begin
      fn(7 + i, 6'h23 + 6'(i));
      fm.set(7 + i, 1'b1);
      settle();
      chk("force_src", {force_src_valid, force_src}, 3'h4 + i);
      fm.set(7 + i, 1'b0);
    end
    chk("comm_channel", comm_channel, ch);
    wr(tifd_pkg::OFF_CTRL, 32'h0);
    fm.set(8, 1'b1);
    settle();
    chk("force_src_valid", force_src_valid, 1'b0);
    // Level functions on one terminal
    for (int i = 0; i < 4; i++) begin
      fn(10, LV_FN[6*i+:6]);
      fm.set(10, 1'b1);
      settle();
      chk("levels", {pid_hold, speed_mode_force, freq_ref_freeze,
        buffer_cab_installed, buffer_contactor_fb},
        (i == 3) ? 5'h3 : (5'h10 >> i));
      fm.set(10, 1'b0);
    end
    settle();
    chk("buffer", {buffer_cab_installed, buffer_contactor_fb}, 2'h2);
    // Breaker feedback through a normally closed contact
    k = $urandom_range(15, 0);
    fn(11, 6'h30 + 6'(k));
    wr(tifd_pkg::OFF_POL, 32'h800);
    settle();
    rd(tifd_pkg::OFF_BRK, 32'h1 << k, 32'hFFFF, 1'b0);
    fm.set(11, 1'b1);
    settle();
    rd(tifd_pkg::OFF_BRK, 32'h0, 32'hFFFF, 1'b0);
    fn(11, 6'h30);
    wr(tifd_pkg::OFF_CTRL, 32'h2);
    fm.set(11, 1'b0);
    settle();
    chk("common_breaker", common_breaker_closed, 1'b1);
    fm.set(11, 1'b1);
    settle();
    chk("common_breaker", common_breaker_closed, 1'b0);
    fm.set(11, 1'b0);
    wr(tifd_pkg::OFF_CTRL, 32'h0);
    settle();
    chk("breakers", {common_breaker_closed, vf_breaker_fb}, 9'h1);
    // Two-wire run decode over every input combination
    fn(14, tifd_pkg::FN_FWD);
    fn(15, tifd_pkg::FN_REV);
    for (int s = 0; s < 2; s++) begin
      wr(tifd_pkg::OFF_SCHEME, s);
      for (int b = 0; b < 4; b++) begin
        fm.set(14, b[0]);
        fm.set(15, b[1]);
        rs(s ? {22'h0, b[1], b[0], 8'h0}
             : {22'h0, b[1] & ~b[0], b[0] ^ b[1], 8'h0}, 32'h300);
      end
    end
    // Three-wire schemes: enable on terminal 13, edges start the run
    fn(13, tifd_pkg::FN_3WIRE);
    wr(tifd_pkg::OFF_SCHEME, 32'h2);
    fm.set(14, 1'b0);
    fm.set(13, 1'b1);
    fm.set(14, 1'b1);
    rs(32'h300, 32'h300);
    fm.set(13, 1'b0);
    rs(32'h200, 32'h300);
    wr(tifd_pkg::OFF_SCHEME, 32'h3);
    fm.set(14, 1'b0);
    fm.set(15, 1'b0);
    fm.set(13, 1'b1);
    fm.set(14, 1'b1);
    rs(32'h100, 32'h300);
    fm.set(15, 1'b1);
    rs(32'h300, 32'h300);
    settle();
    end_of_test();
  end
endmodule // tb_top
